// ---- src/dsd_decoder.sv ----
// data space and program memory address decoder
`timescale 1ns/1ps
module dsd_decoder #(
    parameter bit LARGE = 1'b0,
    parameter int PC_W = LARGE ? dsd_pkg::DSD_PC_W_L : dsd_pkg::DSD_PC_W_S
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic req_valid,
    output logic req_ready,
    input wire dsd_pkg::dsd_op_e req_op,
    input wire dsd_pkg::dsd_mode_e req_mode,
    input wire dsd_pkg::dsd_ptr_e req_ptr,
    input wire logic [5:0] req_disp,
    input wire logic [15:0] req_direct,
    input wire logic [5:0] req_short,
    input wire logic [2:0] req_bit,
    input wire logic [4:0] req_reg,
    output logic done,
    output logic [7:0] rd_data,
    output logic skip,
    input wire logic [PC_W-1:0] program_counter,
    output logic [PC_W-1:0] flash_addr,
    input wire logic [15:0] flash_rdata,
    output logic [7:0] io_addr,
    output logic io_re,
    output logic io_we,
    output logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata
);
    import dsd_pkg::*;

    localparam int SRAM_BYTES = LARGE ? DSD_SRAM_BYTES_L : DSD_SRAM_BYTES_S;
    localparam int SRAM_AW = $clog2(SRAM_BYTES);
    localparam logic [15:0] SRAM_TOP = LARGE ? DSD_SRAM_TOP_L : DSD_SRAM_TOP_S;
    localparam logic [15:0] PM_TOP = LARGE ? DSD_PM_TOP_L : DSD_PM_TOP_S;
    localparam int FLASH_WORDS = LARGE ? DSD_FLASH_WORDS_L : DSD_FLASH_WORDS_S;
    localparam logic [1:0] SCR_NONE = 2'h3;

    typedef enum logic [1:0] {ST_IDLE, ST_SRAM, ST_FLASH} dsd_state_e;

    dsd_state_e state_r;
    logic [7:0] gpr_r [DSD_GPR_COUNT];
    logic [7:0] scratch_r [3];
    logic [4:0] reg_r;
    logic byte_r;
    logic [PC_W-1:0] flash_addr_r;
    logic done_r;
    logic [7:0] rd_data_r;
    logic skip_r;

    logic take;
    logic mem_op;
    logic is_write;
    logic is_rmw;
    logic bit_op;
    logic bit_ok;
    logic [15:0] base;
    logic [15:0] eff;
    logic [15:0] sram_off;
    logic ptr_upd;
    logic [15:0] ptr_new;
    dsd_region_e eff_region;
    logic [1:0] scr;
    logic acc_io;
    logic [7:0] rd_mux;
    logic [7:0] wv;
    logic [7:0] mask;
    logic [15:0] z_ptr;

    dsd_sram_if #(.AW(SRAM_AW)) sbus ();

    function automatic logic [4:0] ptr_lo(input dsd_ptr_e p);
        if (p == PTR_X)
            ptr_lo = DSD_PTR_X_LO;
        else if (p == PTR_Y)
            ptr_lo = DSD_PTR_Y_LO;
        else
            ptr_lo = DSD_PTR_Z_LO;
    endfunction

    function automatic logic [15:0] ptr_value(input dsd_ptr_e p);
        logic [4:0] i;
        i = ptr_lo(p);
        ptr_value = {gpr_r[5'(i + 5'h01)], gpr_r[i]};
    endfunction

    function automatic logic [15:0] to_long(input logic [5:0] s);
        to_long = {10'h000, s} + DSD_IO_BASE;
    endfunction

    function automatic dsd_region_e region_of(input logic [15:0] a);
        if (a <= DSD_GPR_TOP)
            region_of = RG_GPR;
        else if (a <= DSD_IO_TOP)
            region_of = RG_IO;
        else if (a <= DSD_EXT_TOP)
            region_of = RG_EXT;
        else if (a <= SRAM_TOP)
            region_of = RG_SRAM;
        else
            region_of = RG_NONE;
    endfunction

    function automatic logic [1:0] scratch_of(input logic [15:0] a);
        if (a == to_long(DSD_SCRATCH_SHORT0))
            scratch_of = 2'h0;
        else if (a == to_long(DSD_SCRATCH_SHORT1))
            scratch_of = 2'h1;
        else if (a == to_long(DSD_SCRATCH_SHORT2))
            scratch_of = 2'h2;
        else
            scratch_of = SCR_NONE;
    endfunction

    assign take = req_valid && (state_r == ST_IDLE);
    assign req_ready = (state_r == ST_IDLE);
    assign mem_op = !(req_op inside {OP_SKIP_REG_SET, OP_SKIP_REG_CLR, OP_PM_LOAD});
    assign is_rmw = (req_op == OP_SET_PORT_BIT) || (req_op == OP_CLEAR_PORT_BIT);
    assign bit_op = is_rmw || (req_op == OP_SKIP_PORT_SET) || (req_op == OP_SKIP_PORT_CLR);
    assign bit_ok = (req_short <= DSD_BIT_SHORT_TOP);
    assign is_write = (req_op == OP_STORE) || (req_op == OP_PORT_OUT) || is_rmw;
    assign mask = 8'h01 << req_bit;
    assign z_ptr = ptr_value(PTR_Z);

    // effective address and pointer side effects
    always_comb
    begin
        base = ptr_value(req_ptr);
        eff = base;
        ptr_upd = 1'b0;
        ptr_new = base;
        if (req_op == OP_LOAD || req_op == OP_STORE)
        begin
            case (req_mode)
                AM_DIRECT: eff = req_direct;
                AM_INDIRECT: eff = base;
                AM_DISP:
                begin
                    // the x pair has no displaced form, so it falls back to plain indirect
                    if (req_ptr != PTR_X)
                        eff = base + {10'h000, req_disp};
                end
                AM_PREDEC:
                begin
                    eff = base - 16'h0001;
                    ptr_upd = 1'b1;
                    ptr_new = eff;
                end
                AM_POSTINC:
                begin
                    eff = base;
                    ptr_upd = 1'b1;
                    ptr_new = base + 16'h0001;
                end
                default: eff = base;
            endcase
        end
        else if (mem_op)
        begin
            // short forms never pass 0x5F, so the extended area stays out of reach
            eff = to_long(req_short);
        end
    end

    assign eff_region = region_of(eff);
    assign scr = scratch_of(eff);
    assign sram_off = eff - DSD_SRAM_BASE;
    assign acc_io = take && mem_op && (eff_region == RG_IO || eff_region == RG_EXT) && (scr == SCR_NONE);

    always_comb
    begin
        case (eff_region)
            RG_GPR: rd_mux = gpr_r[eff[4:0]];
            RG_IO, RG_EXT: rd_mux = (scr != SCR_NONE) ? scratch_r[scr] : io_rdata;
            default: rd_mux = 8'h00;
        endcase
    end

    always_comb
    begin
        if (req_op == OP_SET_PORT_BIT)
            wv = rd_mux | mask;
        else if (req_op == OP_CLEAR_PORT_BIT)
            wv = rd_mux & ~mask;
        else
            wv = gpr_r[req_reg];
    end

    // peripheral strobes are combinational; read-modify-write reads and writes in one cycle
    assign io_addr = eff[7:0];
    assign io_wdata = wv;
    assign io_re = acc_io && (!is_write || is_rmw) && (!bit_op || bit_ok);
    assign io_we = acc_io && is_write && (!is_rmw || bit_ok);

    assign sbus.en = take && mem_op && (eff_region == RG_SRAM);
    assign sbus.we = is_write;
    assign sbus.addr = sram_off[SRAM_AW-1:0];
    assign sbus.wdata = wv;

    dsd_sram #(
        .DEPTH(SRAM_BYTES),
        .AW(SRAM_AW)
    ) u_sram (
        .sys_clk(sys_clk),
        .rst(rst),
        .bus(sbus)
    );

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            state_r <= ST_IDLE;
        else
        begin
            case (state_r)
                ST_IDLE:
                begin
                    if (take && req_op == OP_PM_LOAD)
                        state_r <= ST_FLASH;
                    else if (sbus.en)
                        state_r <= ST_SRAM;
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // flash word address: fetch follows the program counter unless a table read owns it
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            flash_addr_r <= '0;
            byte_r <= 1'b0;
            reg_r <= 5'h00;
        end
        else
        begin
            if (take)
                reg_r <= req_reg;
            if (take && req_op == OP_PM_LOAD)
            begin
                flash_addr_r <= z_ptr[PC_W:1];
                byte_r <= z_ptr[0];
            end
            else if (state_r != ST_FLASH)
                flash_addr_r <= program_counter;
        end
    end
    assign flash_addr = flash_addr_r;

    // working registers; later writes in the block take precedence
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < DSD_GPR_COUNT; i++)
                gpr_r[i] <= DSD_GPR_RST;
        end
        else
        begin
            if (take && ptr_upd)
            begin
                gpr_r[ptr_lo(req_ptr)] <= ptr_new[7:0];
                gpr_r[5'(ptr_lo(req_ptr) + 5'h01)] <= ptr_new[15:8];
            end
            if (take && (req_op == OP_LOAD || req_op == OP_PORT_IN) && eff_region != RG_SRAM)
                gpr_r[req_reg] <= rd_mux;
            if (take && mem_op && is_write && !is_rmw && eff_region == RG_GPR)
                gpr_r[eff[4:0]] <= wv;
            if (state_r == ST_SRAM && !sbus.we)
                gpr_r[reg_r] <= sbus.rdata;
            if (state_r == ST_FLASH)
                gpr_r[reg_r] <= byte_r ? flash_rdata[15:8] : flash_rdata[7:0];
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < 3; i++)
                scratch_r[i] <= DSD_SCRATCH_RST;
        end
        else if (take && mem_op && is_write && scr != SCR_NONE && (!is_rmw || bit_ok))
            scratch_r[scr] <= wv;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            done_r <= 1'b0;
            rd_data_r <= 8'h00;
            skip_r <= 1'b0;
        end
        else
        begin
            done_r <= 1'b0;
            skip_r <= 1'b0;
            if (state_r == ST_SRAM)
            begin
                done_r <= 1'b1;
                if (!sbus.we)
                    rd_data_r <= sbus.rdata;
            end
            else if (state_r == ST_FLASH)
            begin
                done_r <= 1'b1;
                rd_data_r <= byte_r ? flash_rdata[15:8] : flash_rdata[7:0];
            end
            else if (take && !(mem_op && eff_region == RG_SRAM) && req_op != OP_PM_LOAD)
            begin
                done_r <= 1'b1;
                if (req_op == OP_LOAD || req_op == OP_PORT_IN)
                    rd_data_r <= rd_mux;
                if (req_op == OP_SKIP_PORT_SET && bit_ok)
                    skip_r <= rd_mux[req_bit];
                else if (req_op == OP_SKIP_PORT_CLR && bit_ok)
                    skip_r <= !rd_mux[req_bit];
                else if (req_op == OP_SKIP_REG_SET)
                    skip_r <= gpr_r[req_reg][req_bit];
                else if (req_op == OP_SKIP_REG_CLR)
                    skip_r <= !gpr_r[req_reg][req_bit];
            end
        end
    end

    assign done = done_r;
    assign rd_data = rd_data_r;
    assign skip = skip_r;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    sequence s_take_sram;
        take && mem_op && eff_region == RG_SRAM;
    endsequence
    sequence s_two_cycle_done;
        !done ##1 done;
    endsequence
    sequence s_take_pm;
        take && req_op == OP_PM_LOAD;
    endsequence

    a_sram_two_cycle: assert property (s_take_sram |=> s_two_cycle_done)
        else $error("sram access did not finish in two cycles");
    a_sram_window: assert property (sbus.en |-> eff >= DSD_SRAM_BASE && eff <= SRAM_TOP)
        else $error("sram strobed outside its window");
    a_unmapped_zero: assert property (take && req_op == OP_LOAD && eff_region == RG_NONE
        |=> done && rd_data == 8'h00 && !$past(sbus.en) && !$past(io_we))
        else $error("unmapped load not answered with zero");
    a_port_offset: assert property (take && (req_op == OP_PORT_IN || req_op == OP_PORT_OUT) && scr == SCR_NONE
        |-> (io_re || io_we) && io_addr == 8'(req_short + 6'h00) + 8'h20)
        else $error("port address not offset by 0x20");
    a_io_window: assert property ((io_re || io_we) |-> io_addr >= 8'h20)
        else $error("peripheral strobe below peripheral area");
    a_predec_ptr: assert property (take && req_op == OP_LOAD && req_mode == AM_PREDEC && req_reg < 5'h1A
        && eff_region != RG_GPR |=> ptr_value($past(req_ptr)) == $past(base) - 16'h0001)
        else $error("pointer not decremented");
    a_postinc_ptr: assert property (take && req_op == OP_LOAD && req_mode == AM_POSTINC && req_reg < 5'h1A
        && eff_region != RG_GPR |-> eff == base ##1 ptr_value($past(req_ptr)) == $past(base) + 16'h0001)
        else $error("post-increment used wrong address or pointer");
    a_disp_reach: assert property (take && req_op == OP_STORE && req_mode == AM_DISP && req_ptr != PTR_X
        |-> eff - base == {10'h000, req_disp} && eff - base <= 16'h003F)
        else $error("displacement address wrong");
    a_bit_set: assert property (take && req_op == OP_SET_PORT_BIT && bit_ok && scr == SCR_NONE
        |-> io_we && io_re && (io_wdata & mask) != 8'h00)
        else $error("bit set did not drive the bit");
    a_pm_load: assert property (s_take_pm |=> flash_addr == $past(z_ptr[PC_W:1]) ##1 done)
        else $error("program memory load misrouted");
    a_flash_top: assert property (16'(flash_addr) <= PM_TOP && 16'(flash_addr) < 16'(FLASH_WORDS))
        else $error("flash address beyond program memory");
endmodule // dsd_decoder

// ---- src/dsd_pkg.sv ----
// constants and types shared by the data space decoder files
package dsd_pkg;
    localparam logic [15:0] DSD_GPR_TOP = 16'h001F;
    localparam logic [15:0] DSD_IO_BASE = 16'h0020;
    localparam logic [15:0] DSD_IO_TOP = 16'h005F;
    localparam logic [15:0] DSD_EXT_TOP = 16'h00FF;
    localparam logic [15:0] DSD_SRAM_BASE = 16'h0100;
    localparam logic [15:0] DSD_SRAM_TOP_S = 16'h01FF;
    localparam logic [15:0] DSD_SRAM_TOP_L = 16'h02FF;
    localparam int DSD_SRAM_BYTES_S = 256;
    localparam int DSD_SRAM_BYTES_L = 512;
    localparam int DSD_GPR_COUNT = 32;
    localparam int DSD_FLASH_WORDS_S = 4096;
    localparam int DSD_FLASH_WORDS_L = 8192;
    localparam int DSD_PC_W_S = 11;
    localparam int DSD_PC_W_L = 12;
    localparam logic [15:0] DSD_PM_TOP_S = 16'h07FF;
    localparam logic [15:0] DSD_PM_TOP_L = 16'h0FFF;
    localparam logic [5:0] DSD_BIT_SHORT_TOP = 6'h1F;
    localparam logic [5:0] DSD_SCRATCH_SHORT0 = 6'h1C;
    localparam logic [5:0] DSD_SCRATCH_SHORT1 = 6'h1D;
    localparam logic [5:0] DSD_SCRATCH_SHORT2 = 6'h1E;
    localparam logic [7:0] DSD_SCRATCH_RST = 8'h00;
    localparam logic [7:0] DSD_GPR_RST = 8'h00;
    localparam logic [4:0] DSD_PTR_X_LO = 5'h1A;
    localparam logic [4:0] DSD_PTR_Y_LO = 5'h1C;
    localparam logic [4:0] DSD_PTR_Z_LO = 5'h1E;
    localparam int DSD_SRAM_CYCLES = 2;

    typedef enum logic [3:0] {
        OP_LOAD, OP_STORE, OP_PORT_IN, OP_PORT_OUT, OP_SET_PORT_BIT, OP_CLEAR_PORT_BIT,
        OP_SKIP_PORT_SET, OP_SKIP_PORT_CLR, OP_SKIP_REG_SET, OP_SKIP_REG_CLR, OP_PM_LOAD
    } dsd_op_e;
    typedef enum logic [2:0] {AM_DIRECT, AM_INDIRECT, AM_DISP, AM_PREDEC, AM_POSTINC} dsd_mode_e;
    typedef enum logic [1:0] {PTR_X, PTR_Y, PTR_Z} dsd_ptr_e;
    typedef enum logic [2:0] {RG_GPR, RG_IO, RG_EXT, RG_SRAM, RG_NONE} dsd_region_e;
endpackage

// ---- src/dsd_sram.sv ----
// internal data sram, registered read
`timescale 1ns/1ps
module dsd_sram #(
    parameter int DEPTH = 256,
    parameter int AW = 8
) (
    input wire logic sys_clk,
    input wire logic rst,
    dsd_sram_if.mem bus
);
    import dsd_pkg::*;

    logic [7:0] mem_r [DEPTH];

    always_ff @(posedge sys_clk)
    begin
        if (bus.en && bus.we)
        begin
            mem_r[bus.addr] <= bus.wdata;
        end
    end

    // read data lands one edge after the strobe
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            bus.rdata <= 8'h00;
        end
        else if (bus.en && !bus.we)
        begin
            bus.rdata <= mem_r[bus.addr];
        end
    end
endmodule // dsd_sram

// ---- src/dsd_sram_if.sv ----
// port bundle between the decoder and its sram
`timescale 1ns/1ps
interface dsd_sram_if #(parameter int AW = 8);
    logic en;
    logic we;
    logic [AW-1:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport ctrl (output en, output we, output addr, output wdata, input rdata);
    modport mem (input en, input we, input addr, input wdata, output rdata);
endinterface

// ---- tb/dsd_far_model.sv ----
// peripheral register file and flash array seen from the decoder
`timescale 1ns/1ps
module dsd_far_model #(
    parameter int PC_W = 11
) (
    input wire logic sys_clk,
    input wire logic [7:0] io_addr,
    input wire logic io_re,
    input wire logic io_we,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    input wire logic [PC_W-1:0] flash_addr,
    output logic [15:0] flash_rdata
);
    logic [7:0] mem [0:255];
    logic [7:0] idle_pat = 8'h00;

    // identity contents make every read self-describing
    initial
    begin
        for (int i = 0; i < 256; i++)
            mem[i] = i[7:0];
    end

    always @(posedge sys_clk)
    begin
        idle_pat <= idle_pat + 8'h5B;
        if (io_we === 1'b1)
            mem[io_addr] <= io_wdata;
    end

    // undriven read bus churns so a stale value never passes
    assign io_rdata = (io_re === 1'b1) ? mem[io_addr] : idle_pat;
    // high byte carries the upper address bits, so a short reach shows
    assign flash_rdata = {flash_addr[PC_W-1:PC_W-8] ^ 8'h3C, flash_addr[7:0]};
endmodule // dsd_far_model

// ---- tb/testbench.sv ----
// self-checking bench for the data space decoder
`timescale 1ns/1ps
module testbench;
    import dsd_pkg::*;
    logic sys_clk;
    logic rst;
    logic req_valid;
    logic req_ready;
    dsd_op_e req_op;
    dsd_mode_e req_mode;
    dsd_ptr_e req_ptr;
    logic [5:0] req_disp;
    logic [15:0] req_direct;
    logic [5:0] req_short;
    logic [2:0] req_bit;
    logic [4:0] req_reg;
    logic done;
    logic [7:0] rd_data;
    logic skip;
    logic [10:0] program_counter;
    logic [10:0] flash_addr;
    logic [15:0] flash_rdata;
    logic [7:0] io_addr;
    logic io_re;
    logic io_we;
    logic [7:0] io_wdata;
    logic [7:0] io_rdata;
    int errors = 0;
    int checks_done = 0;
    int lat;
    int strobes = 0;
    int s0;
    logic sk;
    logic [7:0] last_io;

    dsd_decoder #(.LARGE(1'b0)) i_dsd_decoder (.sys_clk(sys_clk), .rst(rst), .req_valid(req_valid),
        .req_ready(req_ready), .req_op(req_op), .req_mode(req_mode), .req_ptr(req_ptr), .req_disp(req_disp),
        .req_direct(req_direct), .req_short(req_short), .req_bit(req_bit), .req_reg(req_reg), .done(done),
        .rd_data(rd_data), .skip(skip), .program_counter(program_counter), .flash_addr(flash_addr),
        .flash_rdata(flash_rdata), .io_addr(io_addr), .io_re(io_re), .io_we(io_we), .io_wdata(io_wdata),
        .io_rdata(io_rdata));
    dsd_far_model #(.PC_W(11)) i_dsd_far_model (.sys_clk(sys_clk), .io_addr(io_addr), .io_re(io_re),
        .io_we(io_we), .io_wdata(io_wdata), .io_rdata(io_rdata), .flash_addr(flash_addr),
        .flash_rdata(flash_rdata));

    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // peripheral strobe monitor, sampled where the transfer lands
    always @(posedge sys_clk)
    begin
        if (io_re === 1'b1 || io_we === 1'b1)
        begin
            strobes++;
            last_io = io_addr;
        end
    end

    task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_cnt(input string what, input int exp, input int got);
        checks_done++;
        if (got != exp)
        begin
            errors++;
            $display("unexpected %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    // one request, held for a single clock edge, then a bounded wait for done
    task automatic issue(input dsd_op_e op, input dsd_mode_e md, input dsd_ptr_e pt, input logic [5:0] dp,
        input logic [15:0] ad, input logic [2:0] bt, input logic [4:0] rg);
        req_op = op;
        req_mode = md;
        req_ptr = pt;
        req_disp = dp;
        req_direct = ad;
        req_short = ad[5:0];
        req_bit = bt;
        req_reg = rg;
        req_valid = 1'b1;
        @(posedge sys_clk);
        #1;
        req_valid = 1'b0;
        lat = 1;
        while (done !== 1'b1 && lat < 6)
        begin
            @(posedge sys_clk);
            #1;
            lat++;
        end
        sk = skip;
    endtask

    task automatic ld(input logic [15:0] ad, input logic [4:0] rg);
        issue(OP_LOAD, AM_DIRECT, PTR_X, 6'h00, ad, 3'h0, rg);
    endtask

    task automatic st(input logic [15:0] ad, input logic [4:0] rg);
        issue(OP_STORE, AM_DIRECT, PTR_X, 6'h00, ad, 3'h0, rg);
    endtask

    task automatic s_regions;
        logic [15:0] tab [4] = '{16'h0020, 16'h005F, 16'h0060, 16'h00FF};
        foreach (tab[i])
        begin
            s0 = strobes;
            ld(tab[i], 5'h01);
            chk_cnt("io load strobes", s0 + 1, strobes);
            chk_val("io load address", tab[i][7:0], last_io);
            chk_val("io load data", tab[i][7:0], rd_data);
        end
        s0 = strobes;
        ld(16'h001F, 5'h02);
        chk_val("register file read", 16'h0000, rd_data);
        st(DSD_SRAM_BASE, 5'h01);
        chk_cnt("sram store cycles", DSD_SRAM_CYCLES, lat);
        st(DSD_SRAM_TOP_S, 5'h01);
        st(16'h0200, 5'h00);
        ld(16'h0200, 5'h03);
        chk_val("unmapped read", 16'h0000, rd_data);
        ld(DSD_SRAM_BASE, 5'h03);
        chk_val("sram base kept", 16'h00FF, rd_data);
        ld(DSD_SRAM_TOP_S, 5'h03);
        chk_cnt("sram load cycles", DSD_SRAM_CYCLES, lat);
        chk_val("sram top", 16'h00FF, rd_data);
        chk_val("ready when idle", 16'h0001, req_ready);
        req_direct = DSD_SRAM_BASE;
        req_valid = 1'b1;
        @(posedge sys_clk);
        #1;
        req_valid = 1'b0;
        chk_val("ready during sram access", 16'h0000, req_ready);
        @(posedge sys_clk);
        #1;
        chk_val("done after second sram cycle", 16'h0001, done);
        chk_val("ready after sram access", 16'h0001, req_ready);
        chk_cnt("no io strobe outside io", s0, strobes);
    endtask

    task automatic s_port;
        issue(OP_PORT_IN, AM_DIRECT, PTR_X, 6'h00, 16'h0000, 3'h0, 5'h04);
        chk_val("short zero address", 16'h0020, last_io);
        chk_val("short zero data", 16'h0020, rd_data);
        issue(OP_PORT_IN, AM_DIRECT, PTR_X, 6'h00, 16'h003F, 3'h0, 5'h04);
        chk_val("short top stays in io", 16'h005F, last_io);
        issue(OP_CLEAR_PORT_BIT, AM_DIRECT, PTR_X, 6'h00, 16'h0001, 3'h5, 5'h00);
        issue(OP_SKIP_PORT_SET, AM_DIRECT, PTR_X, 6'h00, 16'h0001, 3'h0, 5'h00);
        chk_val("skip on set bit", 16'h0001, sk);
        issue(OP_SKIP_PORT_CLR, AM_DIRECT, PTR_X, 6'h00, 16'h0001, 3'h0, 5'h00);
        chk_val("no skip on set bit", 16'h0000, sk);
        issue(OP_SKIP_PORT_CLR, AM_DIRECT, PTR_X, 6'h00, 16'h0001, 3'h5, 5'h00);
        chk_val("skip on cleared bit", 16'h0001, sk);
        s0 = strobes;
        issue(OP_SET_PORT_BIT, AM_DIRECT, PTR_X, 6'h00, 16'h0020, 3'h0, 5'h00);
        chk_cnt("bit op above 0x1F", s0, strobes);
        chk_cnt("refused bit op done", 1, lat);
        issue(OP_CLEAR_PORT_BIT, AM_DIRECT, PTR_X, 6'h00, 16'h000F, 3'h5, 5'h00);
        // only plain data goes to unreserved places
        issue(OP_PORT_OUT, AM_DIRECT, PTR_X, 6'h00, 16'h0010, 3'h0, 5'h01);
        ld(16'h0030, 5'h04);
        chk_val("port write seen long", 16'h00FF, rd_data);
    endtask

    task automatic s_scratch;
        s0 = strobes;
        for (int k = 0; k < 3; k++)
        begin
            issue(OP_SET_PORT_BIT, AM_DIRECT, PTR_X, 6'h00, 16'h001C + k, k + 1, 5'h00);
            ld(16'h003C + k, 5'h04);
            chk_val("scratch value", 16'h0001 << (k + 1), rd_data);
            issue(OP_SKIP_PORT_SET, AM_DIRECT, PTR_X, 6'h00, 16'h001C + k, k + 1, 5'h00);
            chk_val("scratch skip set", 16'h0001, sk);
            issue(OP_CLEAR_PORT_BIT, AM_DIRECT, PTR_X, 6'h00, 16'h001C + k, k + 1, 5'h00);
            issue(OP_SKIP_PORT_CLR, AM_DIRECT, PTR_X, 6'h00, 16'h001C + k, k + 1, 5'h00);
            chk_val("scratch skip clear", 16'h0001, sk);
        end
        chk_cnt("scratch kept inside", s0, strobes);
    endtask

    task automatic s_pointer;
        ld(16'h0050, 5'h1A);
        ld(16'h0021, 5'h1B);
        issue(OP_STORE, AM_POSTINC, PTR_X, 6'h00, 16'h0000, 3'h0, 5'h1A);
        ld(16'h001A, 5'h05);
        chk_val("pointer after increment", 16'h0051, rd_data);
        ld(16'h0150, 5'h06);
        chk_val("post increment used old", 16'h0050, rd_data);
        issue(OP_LOAD, AM_PREDEC, PTR_X, 6'h00, 16'h0000, 3'h0, 5'h07);
        chk_val("pre decrement access", 16'h0050, rd_data);
        ld(16'h001A, 5'h05);
        chk_val("pointer after decrement", 16'h0050, rd_data);
        issue(OP_LOAD, AM_INDIRECT, PTR_X, 6'h00, 16'h0000, 3'h0, 5'h08);
        chk_val("indirect pair", 16'h0050, rd_data);
        st(16'h001D, 5'h1B);
        issue(OP_STORE, AM_DISP, PTR_Y, 6'h3F, 16'h0000, 3'h0, 5'h1A);
        ld(16'h013F, 5'h09);
        chk_val("displacement 63", 16'h0050, rd_data);
        issue(OP_LOAD, AM_DISP, PTR_Y, 6'h00, 16'h0000, 3'h0, 5'h09);
        chk_val("displacement zero", 16'h00FF, rd_data);
        issue(OP_SKIP_REG_SET, AM_DIRECT, PTR_X, 6'h00, 16'h0000, 3'h0, 5'h1B);
        chk_val("register bit skip", 16'h0001, sk);
        issue(OP_SKIP_REG_CLR, AM_DIRECT, PTR_X, 6'h00, 16'h0000, 3'h0, 5'h1B);
        chk_val("register bit no skip", 16'h0000, sk);
    endtask

    task automatic s_flash;
        ld(16'h002F, 5'h1F);
        ld(16'h00FF, 5'h1E);
        issue(OP_PM_LOAD, AM_DIRECT, PTR_Z, 6'h00, 16'h0000, 3'h0, 5'h0A);
        chk_cnt("program load cycles", 2, lat);
        chk_val("top flash word high byte", 16'h00C3, rd_data);
        st(16'h001F, 5'h00);
        issue(OP_LOAD, AM_POSTINC, PTR_Z, 6'h00, 16'h0000, 3'h0, 5'h0A);
        chk_val("pointer into io", 16'h00FF, last_io);
        issue(OP_PM_LOAD, AM_DIRECT, PTR_Z, 6'h00, 16'h0000, 3'h0, 5'h0A);
        chk_val("flash low byte", 16'h0080, rd_data);
        program_counter = 11'h7FF;
        repeat (2) @(posedge sys_clk);
        #1;
        chk_val("fetch top address", 16'h07FF, {5'h00, flash_addr});
        program_counter = 11'h2A5;
        repeat (2) @(posedge sys_clk);
        #1;
        chk_val("fetch counter width", 16'h02A5, {5'h00, flash_addr});
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        #50000;
        errors++;
        summarize();
    end

    initial
    begin
        rst = 1'b1;
        req_valid = 1'b0;
        req_op = OP_LOAD;
        req_mode = AM_DIRECT;
        req_ptr = PTR_X;
        req_disp = 6'h00;
        req_direct = 16'h0000;
        req_short = 6'h00;
        req_bit = 3'h0;
        req_reg = 5'h00;
        program_counter = 11'h000;
        repeat (3) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        s_regions();
        s_port();
        s_scratch();
        s_pointer();
        s_flash();
        summarize();
    end
endmodule // testbench
